// [rtl/fbeg_guard.sv]
// fbeg_guard: error byte reporting for the boot serial protocol and the
// guard around flash programming/erasing and routine download.
// assumes command decoding and the byte transmitter sit outside; all
// inputs except chip_clear_input_n come from logic on clk_i.
// What this block does
// - distinct codes for device and clock-mode mismatch
// - each clocking problem has its own code
// - flash refused until write key cleared
// - routines may overwrite first two general registers
// - each downloaded routine at most 4 Kbytes
// - failure replies error response then code
// - state inquiry error byte zero or one
`default_nettype none
module fbeg_guard #(
	parameter int unsigned RESET_HOLD = fbeg_pkg::RESET_HOLD_CYC
) (
	// clock, reset and the raw chip clear pin
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic chip_clear_input_n,

	// command outcome from the protocol decoder
	input wire logic cmd_done_i,
	input wire logic cmd_ok_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [fbeg_pkg::NCAUSE-1:0] cause_i,

	// reply bytes towards the serial transmitter
	input wire logic tx_ready_i,
	output logic tx_valid_o,
	output logic [7:0] tx_byte_o,
	output logic [7:0] err_status_o,
	output logic [7:0] last_err_o,

	// program/erase guard and routine download
	input wire logic flash_write_key_i,
	input wire logic pe_start_i,
	input wire logic pe_active_i,
	input wire logic routine_download_request_i,
	input wire logic [12:0] routine_len_i,
	output logic flash_access_ok_o,
	output logic routine_len_err_o,
	output logic gr_clobber_o,
	output logic reset_hold_short_o
);
	// lowest set cause wins; order follows the code table
	function automatic logic [7:0] cause_code(input logic [fbeg_pkg::NCAUSE-1:0] c);
		logic [7:0] t [fbeg_pkg::NCAUSE];
		t = '{
			fbeg_pkg::ERR_SUM,
			fbeg_pkg::ERR_PSIZE,
			fbeg_pkg::ERR_DEV,
			fbeg_pkg::ERR_CLKMODE,
			fbeg_pkg::ERR_BITRATE,
			fbeg_pkg::ERR_INFREQ,
			fbeg_pkg::ERR_MULT,
			fbeg_pkg::ERR_OPFREQ,
			fbeg_pkg::ERR_BLOCK,
			fbeg_pkg::ERR_ADDR,
			fbeg_pkg::ERR_LEN,
			fbeg_pkg::ERR_ERASE,
			fbeg_pkg::ERR_ERINC,
			fbeg_pkg::ERR_PROG,
			fbeg_pkg::ERR_SEL,
			fbeg_pkg::ERR_CMD,
			fbeg_pkg::ERR_ADJ
		};
		// no cause flagged still reports a failure, as a command error
		cause_code = fbeg_pkg::ERR_CMD;
		for (int i = fbeg_pkg::NCAUSE - 1; i >= 0; i--) begin
			if (c[i]) begin
				cause_code = t[i];
			end
		end
	endfunction

	typedef enum logic [2:0] {
		FBEG_IDLE = 3'b001,
		FBEG_RESP = 3'b010,
		FBEG_CODE = 3'b100
	} fbeg_tx_e;

	// reply sequencer
	fbeg_tx_e state_q;
	logic [7:0] resp_q;

	// error memory
	logic [7:0] err_q;
	logic err_flag_q;

	// flash guard
	logic lock_q;

	// reset pin hold-time watch
	logic [2:0] rst_sync_q;
	logic rst_low;
	logic [31:0] low_cnt_q;
	logic pe_seen_q;

	// two-byte failure reply, single ack on success
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q <= FBEG_IDLE;
			resp_q <= 8'h00;
		end else begin
			case (state_q)
				FBEG_IDLE: begin
					if (cmd_done_i) begin
						resp_q <= cmd_ok_i ? fbeg_pkg::ACK
							: (cmd_code_i | fbeg_pkg::ERR_RESP_OFS);
						state_q <= FBEG_RESP;
					end
				end
				FBEG_RESP: begin
					if (tx_ready_i) begin
						resp_q <= err_q;
						state_q <= err_flag_q ? FBEG_CODE : FBEG_IDLE;
					end
				end
				FBEG_CODE: begin
					if (tx_ready_i) begin
						state_q <= FBEG_IDLE;
					end
				end
				default: state_q <= FBEG_IDLE;
			endcase
		end
	end

	// code held until the next command taken in idle replaces it
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			err_q <= fbeg_pkg::ERR_NONE;
			err_flag_q <= 1'b0;
		end else if (cmd_done_i && state_q == FBEG_IDLE) begin
			err_q <= cmd_ok_i ? fbeg_pkg::ERR_NONE : cause_code(cause_i);
			err_flag_q <= !cmd_ok_i;
		end
	end

	assign tx_valid_o = (state_q != FBEG_IDLE);
	assign tx_byte_o = resp_q;
	assign err_status_o = err_flag_q ? fbeg_pkg::STAT_ERR : fbeg_pkg::STAT_OK;
	assign last_err_o = err_q;

	// start wins over a same-cycle key clear; lock drops only once key is clear
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			lock_q <= 1'b0;
		end else if (pe_start_i) begin
			lock_q <= 1'b1;
		end else if (!flash_write_key_i) begin
			lock_q <= 1'b0;
		end
	end
	assign flash_access_ok_o = !lock_q && !pe_start_i;

	// routine size is checked, not trusted
	assign routine_len_err_o = routine_download_request_i
		&& (32'(routine_len_i) > fbeg_pkg::ROUTINE_MAX_BYTES);
	// caller must save the two general registers while this is high
	assign gr_clobber_o = routine_download_request_i || pe_active_i || lock_q;

	// reset pin is asynchronous: three stages, low counts only while stages 2 and 3 both read low
	always_ff @(posedge clk_i) begin
		rst_sync_q <= {rst_sync_q[1:0], chip_clear_input_n};
	end
	assign rst_low = !rst_sync_q[1] && !rst_sync_q[2];

	// remembers that programming or erasing has been under way
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pe_seen_q <= 1'b0;
		end else if (pe_active_i || pe_start_i) begin
			pe_seen_q <= 1'b1;
		end
	end

	// length of the current low phase of the pin; saturates, never wraps
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			low_cnt_q <= 32'h0000_0000;
		end else if (rst_low) begin
			if (low_cnt_q != 32'hFFFF_FFFF) begin
				low_cnt_q <= low_cnt_q + 32'h0000_0001;
			end
		end else begin
			low_cnt_q <= 32'h0000_0000;
		end
	end

	// flags a reset pulse shorter than the hold time after programming activity
	// the flag is sticky: only the system reset clears it
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			reset_hold_short_o <= 1'b0;
		end else if (!rst_low && pe_seen_q && low_cnt_q != 32'h0000_0000
			&& low_cnt_q < RESET_HOLD) begin
			reset_hold_short_o <= 1'b1;
		end
	end

	// a flag only: the pulse has already reached the chip, nothing is undone
endmodule
`default_nettype wire

// [shared/fbeg_pkg.sv]
// fbeg_pkg: error codes, response bytes and timing constants for the flash
// boot error and program guard block.
// assumes a 250 MHz system clock.
`default_nettype none
package fbeg_pkg;
	localparam int unsigned CLK_MHZ = 250;
	// error codes sent to the host
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_SUM = 8'h11;
	localparam logic [7:0] ERR_PSIZE = 8'h12;
	localparam logic [7:0] ERR_DEV = 8'h21;
	localparam logic [7:0] ERR_CLKMODE = 8'h22;
	localparam logic [7:0] ERR_BITRATE = 8'h24;
	localparam logic [7:0] ERR_INFREQ = 8'h25;
	localparam logic [7:0] ERR_MULT = 8'h26;
	localparam logic [7:0] ERR_OPFREQ = 8'h27;
	localparam logic [7:0] ERR_BLOCK = 8'h29;
	localparam logic [7:0] ERR_ADDR = 8'h2A;
	localparam logic [7:0] ERR_LEN = 8'h2B;
	localparam logic [7:0] ERR_ERASE = 8'h51;
	localparam logic [7:0] ERR_ERINC = 8'h52;
	localparam logic [7:0] ERR_PROG = 8'h53;
	localparam logic [7:0] ERR_SEL = 8'h54;
	localparam logic [7:0] ERR_CMD = 8'h80;
	localparam logic [7:0] ERR_ADJ = 8'hFF;
	// error cause index (one input bit each)
	localparam int unsigned NCAUSE = 17;
	localparam logic [7:0] ACK = 8'h06;
	localparam logic [7:0] ERR_RESP_OFS = 8'h80;
	localparam logic [7:0] STAT_OK = 8'h00;
	localparam logic [7:0] STAT_ERR = 8'h01;
	localparam int unsigned PROG_UNIT_BYTES = 128;
	localparam int unsigned ROUTINE_MAX_BYTES = 4096;
	localparam int unsigned RESET_HOLD_US = 100;
	localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_US * CLK_MHZ;
	localparam int unsigned DUMMY_READS = 2;
endpackage
`default_nettype wire

// [tb/fbeg_guard_props.sv]
// checker: reply bytes, error codes, lock and guards
// assumes bind into fbeg_guard
`default_nettype none
module fbeg_guard_props (
	input wire logic clk_i, srst_i, cmd_done_i, cmd_ok_i, tx_ready_i, tx_valid_o,
	input wire logic pe_start_i, pe_active_i, flash_access_ok_o, gr_clobber_o,
	input wire logic routine_download_request_i, routine_len_err_o,
	input wire logic [7:0] cmd_code_i, tx_byte_o, err_status_o, last_err_o,
	input wire logic [fbeg_pkg::NCAUSE-1:0] cause_i,
	input wire logic [12:0] routine_len_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	wire logic tk = cmd_done_i && !tx_valid_o;
	wire logic bad = tk && !cmd_ok_i;
	ack_byte_a: assert property (tk && cmd_ok_i |=> tx_valid_o && tx_byte_o == 8'h06)
		else $error("ack");
	resp_byte_a: assert property (bad |=> tx_byte_o == ($past(cmd_code_i) | 8'h80))
		else $error("resp");
	dev_code_a: assert property (bad && cause_i == 17'h4 |=> last_err_o == 8'h21)
		else $error("dev");
	clk_code_a: assert property (bad && cause_i == 17'h10 ##1 tx_ready_i
		|=> tx_valid_o && tx_byte_o == 8'h24) else $error("clk");
	lock_a: assert property (pe_start_i |-> !flash_access_ok_o) else $error("lock");
	len_err_a: assert property (routine_len_err_o ==
		(routine_download_request_i && routine_len_i > 13'h1000)) else $error("len");
	clobber_a: assert property (pe_active_i |-> gr_clobber_o) else $error("clob");
	status_a: assert property (
		err_status_o == {7'h0, last_err_o != 8'h00}) else $error("stat");
	keep_err_a: assert property (!tk |=> $stable(last_err_o)) else $error("keep");
	cover property (tk && cmd_ok_i);
	cover property (bad ##1 tx_ready_i);
	cover property (pe_start_i);
endmodule
`default_nettype wire

// [tb/fbeg_host.sv]
// host model: collects reply bytes, may stall
// assumes the guard's clock
`default_nettype none
module fbeg_host (
	input wire logic clk_i,
	input wire logic slow_i,
	input wire logic valid_i,
	input wire logic [7:0] byte_i,
	output logic ready_o
);
	logic [1:0] cnt_q = 2'h0;
	logic [7:0] rx_q [$];
	// a slow host takes one byte in four cycles, stretching each reply
	assign ready_o = !slow_i || cnt_q == 2'h0;
	always @(posedge clk_i) begin
		cnt_q <= cnt_q + 2'h1;
		if (valid_i && ready_o) rx_q.push_back(byte_i);
	end
endmodule
`default_nettype wire

// [tb/fbeg_guard_bench.sv]
// bench: random and corner commands, lock and length checks
// assumes fbeg_host and the checker compiled first
`default_nettype none
module fbeg_guard_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, srst_i = 1, dn = 0, ok = 0, key = 0, ps = 0, ac = 0, sl = 0, rq = 0;
	logic pn = 1, hs;
	logic [7:0] cd = 8'h00;
	logic [16:0] ca = 17'h0;
	logic [12:0] ln = 13'h0;
	logic tv, rd, aok, le, cl;
	logic [7:0] tb, es, ls;
	logic [31:0] r = 32'h55b9;
	int n_errors = 0, n_tests = 0;
	logic [7:0] tbl [17] = '{8'h11, 8'h12, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h27, 8'h29,
		8'h2A, 8'h2B, 8'h51, 8'h52, 8'h53, 8'h54, 8'h80, 8'hFF};
	fbeg_guard #(.RESET_HOLD(20)) u_dut (.clk_i, .srst_i, .chip_clear_input_n(pn),
		.cmd_done_i(dn), .cmd_ok_i(ok), .cmd_code_i(cd), .cause_i(ca), .tx_ready_i(rd),
		.tx_valid_o(tv), .tx_byte_o(tb), .err_status_o(es), .last_err_o(ls),
		.flash_write_key_i(key), .pe_start_i(ps), .pe_active_i(ac),
		.routine_download_request_i(rq), .routine_len_i(ln), .flash_access_ok_o(aok),
		.routine_len_err_o(le), .gr_clobber_o(cl), .reset_hold_short_o(hs));
	fbeg_host u_host (.clk_i, .slow_i(sl), .valid_i(tv), .byte_i(tb), .ready_o(rd));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		n_tests++;
		if (got !== want) begin
			n_errors++;
			$display("mismatch %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic cmd(input logic o, input logic [7:0] c, input logic [16:0] k);
		logic [7:0] e;
		e = 8'h80;
		for (int i = 16; i >= 0; i--) if (k[i]) e = tbl[i];
		u_host.rx_q.delete();
		{dn, ok, cd, ca} = {1'b1, o, c, k};
		@(negedge clk_i) dn = 0;
		repeat (40) if (u_host.rx_q.size() < 2 - o) @(negedge clk_i);
		chk(u_host.rx_q[0], o ? 8'h06 : c | 8'h80);
		if (!o) chk(u_host.rx_q[1], e);
		chk(ls, o ? 8'h00 : e);
		chk(es, {7'h0, !o});
		@(negedge clk_i);
	endtask
	initial forever #2 clk_i = ~clk_i;
	initial begin
		#100000;
		n_errors++;
		stop_test();
	end
	initial begin
		repeat (3) @(negedge clk_i);
		srst_i = 0;
		for (int i = 0; i < 17; i++) cmd(0, 8'h50, 17'h1 << i);
		cmd(0, 8'h58, 17'h0);
		cmd(1, 8'h4F, 17'h0);
		for (int i = 0; i < 30; i++) begin
			r = xs(r);
			sl = r[8];
			cmd(r[9], {1'b0, r[6:0]}, r[26:10]);
		end
		// start once with the write key set, then activity and a 4096-byte download
		{key, ps} = 2'h3;
		#1 chk(aok, 8'h00);
		@(negedge clk_i) {ps, ac, rq, ln} = {3'h3, 13'h1000};
		#1 chk(le, 8'h00);
		@(negedge clk_i) ln = 13'h1001;
		// download request held, not cleared straight away
		repeat (4) @(negedge clk_i);
		chk(le, 8'h01);
		chk(aok, 8'h00);
		chk(cl, 8'h01);
		{key, ps, ac, rq} = 4'h0;
		repeat (3) @(negedge clk_i);
		chk(aok, 8'h01);
		pn = 0;
		repeat (30) @(negedge clk_i);
		pn = 1;
		repeat (6) @(negedge clk_i);
		chk(hs, 8'h00);
		pn = 0;
		repeat (5) @(negedge clk_i);
		pn = 1;
		repeat (6) @(negedge clk_i);
		chk(hs, 8'h01);
		srst_i = 1;
		@(negedge clk_i) srst_i = 0;
		chk(ls, 8'h00);
		chk(hs, 8'h00);
		stop_test();
	end
endmodule
bind fbeg_guard fbeg_guard_props u_props (.*);
`default_nettype wire
